// ---- core/far_pkg.sv ----
// package: constants, fault layout and types for the fault auto-retry controller
package far_pkg;

	// clock and time base
	localparam int unsigned CLK_FREQ_HZ    = 200_000_000;
	localparam int unsigned WAIT_UNIT_MS   = 100;
	localparam int unsigned TICK_CYCLES    = CLK_FREQ_HZ / 1000 * WAIT_UNIT_MS;

	// wait time setting in 100 ms units (0.1 s to 360 s, default 1 s)
	localparam int unsigned WAIT_W         = 12;
	localparam logic [11:0] WAIT_MIN       = 12'h001;
	localparam logic [11:0] WAIT_MAX       = 12'hE10;
	localparam logic [11:0] WAIT_DFLT      = 12'h00A;
	localparam logic [2:0]  WINDOW_MULT    = 3'h5;
	localparam int unsigned TICKS_W        = 16;

	// fault class selection (0 to 3, default 0)
	localparam logic [1:0]  CLASS_ALL      = 2'h0;
	localparam logic [1:0]  CLASS_OC       = 2'h1;
	localparam logic [1:0]  CLASS_OV       = 2'h2;
	localparam logic [1:0]  CLASS_OC_OV    = 2'h3;
	localparam logic [1:0]  CLASS_DFLT     = 2'h0;

	// attempt limit setting (0 off, 1..10 quiet, 101..110 with alarm)
	localparam logic [6:0]  LIMIT_OFF      = 7'h00;
	localparam logic [6:0]  LIMIT_MAX      = 7'h0A;
	localparam logic [6:0]  LIMIT_ALM_BASE = 7'h64;
	localparam logic [6:0]  LIMIT_ALM_MIN  = 7'h65;
	localparam logic [6:0]  LIMIT_ALM_MAX  = 7'h6E;

	// fault vector layout: field order fixes bit positions, bit 17 first
	localparam int unsigned FAULT_W        = 18;
	typedef struct packed {
		logic overcurrent_trip_accel;
		logic overcurrent_trip_const_speed;
		logic overcurrent_trip_decel_stop;
		logic overvoltage_trip_accel;
		logic overvoltage_trip_const_speed;
		logic overvoltage_trip_decel_stop;
		logic motor_thermal_overload;
		logic drive_thermal_overload;
		logic fin_overheat_fault;
		logic brake_switch_fault;
		logic output_ground_fault;
		logic output_phase_loss;
		logic external_thermal_relay_trip;
		logic power_limit_stall_trip;
		logic communication_fault;
		logic parameter_fault;
		logic panel_disconnect_fault;
		logic processor_fault;
	} far_fault_s;

	// eligibility masks over the fault vector
	localparam logic [17:0] MASK_OC        = 18'h38000;
	localparam logic [17:0] MASK_OV        = 18'h07000;
	localparam logic [17:0] MASK_ALL       = 18'h3FD3C;
	localparam logic [17:0] MASK_NEVER     = 18'h002C3;

	// fault record codes: bit index plus one, zero means empty
	localparam logic [4:0]  CODE_NONE      = 5'h00;
	localparam logic [4:0]  CODE_RET       = 5'h13;

	// success counter
	localparam int unsigned CNT_W          = 16;

	// controller states
	typedef enum logic [2:0] {
		ST_RUN     = 3'b000,
		ST_WAIT    = 3'b001,
		ST_RESTART = 3'b010,
		ST_WATCH   = 3'b011,
		ST_STOPPED = 3'b100
	} far_state_e;

	// settings group
	typedef struct packed {
		logic [1:0]  retry_fault_class_select;
		logic [6:0]  retry_attempt_limit;
		logic [11:0] retry_wait_time;
	} far_cfg_s;

endpackage : far_pkg

// ---- core/far_timer.sv ----
// module: tick prescaler and down-counter for waiting and watch windows
`timescale 1ns/100ps
`default_nettype none

module far_timer #(
	parameter int unsigned TICK_CYCLES = far_pkg::TICK_CYCLES,
	parameter int unsigned TICKS_W     = far_pkg::TICKS_W
) (
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	// control
	input  wire logic               i_start,
	input  wire logic               i_cancel,
	input  wire logic [TICKS_W-1:0] i_ticks,
	// status
	output logic                    o_busy,
	output logic                    o_done
);

	typedef struct packed {
		logic               busy;
		logic               done;
		logic [31:0]        presc;
		logic [TICKS_W-1:0] ticks;
	} far_tmr_s;

	far_tmr_s st_r;
	far_tmr_s st_nxt;

	// next state: a start restarts from scratch, cancel only stops
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		if (i_start) begin
			st_nxt.busy  = 1'b1;
			st_nxt.presc = TICK_CYCLES - 1;
			// a zero load still waits one tick, never zero time
			st_nxt.ticks = (i_ticks == '0) ? TICKS_W'(1) : i_ticks;
		end else if (i_cancel) begin
			st_nxt.busy = 1'b0;
		end else if (st_r.busy) begin
			if (st_r.presc != 32'h0) begin
				st_nxt.presc = st_r.presc - 32'h1;
			end else if (st_r.ticks == TICKS_W'(1)) begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
			end else begin
				st_nxt.presc = TICK_CYCLES - 1;
				st_nxt.ticks = st_r.ticks - TICKS_W'(1);
			end
		end
	end

	// state register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_busy = st_r.busy;
	assign o_done = st_r.done;

endmodule : far_timer

`default_nettype wire

// ---- core/far_ctrl.sv ----
// module: fault auto-retry controller for the drive's output stage
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - retry-eligible fault stops output; block self-resets and restarts unaided
// - class select 0..3, default 0, picks which faults are retry eligible
// - class 0 retries overcurrent, overvoltage, thermal, brake, relay, stall, comms, parameter
// - class 1 overcurrent only, 2 overvoltage only, 3 both groups
// - fin overheat, ground, phase loss, panel, limit exceeded, processor never retried
// - limit 0 off, 1..10 quiet attempts, 101..110 attempts with alarm raised
// - wait the programmed 0.1 s to 360 s time before each retry restart; an operator-cleared restart does not wait
// - success counter reads cumulative successful restarts, by retry or by operator clear
// - writing zero clears success counter; other written values ignored
// - count success after five waiting times of fault-free running after a retry or operator-cleared restart
// - faults recurring within the window keep only the first fault recorded
// - retry reset keeps thermal state; only power-on reset clears it
module far_ctrl #(
	parameter int unsigned TICK_CYCLES = far_pkg::TICK_CYCLES,
	parameter int unsigned CNT_W       = far_pkg::CNT_W
) (
	// clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_srst,
	// protective fault detectors, levels held until reset
	input  wire far_pkg::far_fault_s       i_faults,
	// settings
	input  wire far_pkg::far_cfg_s         i_cfg,
	// success counter write port
	input  wire logic                      i_cnt_wr,
	input  wire logic [CNT_W-1:0]          i_cnt_wr_data,
	// operator reset after a hard stop
	input  wire logic                      i_fault_clear,
	// output stage and alarm
	output logic                           o_output_enable,
	output logic                           o_fault_reset,
	output logic                           o_thermal_state_clear,
	output logic                           o_alarm,
	output logic                           o_retry_limit_exceeded_fault,
	// status
	output logic                           o_retry_active,
	output logic [3:0]                     o_retry_attempts,
	output logic [4:0]                     o_retry_fault_record,
	output logic [CNT_W-1:0]               o_retry_success_counter
);

	typedef struct packed {
		far_pkg::far_state_e state;
		logic [3:0]          attempts;
		logic [4:0]          record;
		logic [CNT_W-1:0]    success_cnt;
		logic                fault_reset;
		logic                thermal_clear;
		logic                alarm;
		logic                limit_fault;
		logic                tmr_start;
		logic                tmr_cancel;
		logic [15:0]         tmr_ticks;
	} far_ctrl_s;

	far_ctrl_s st_r;
	far_ctrl_s st_nxt;

	logic        tmr_done;
	logic [17:0] fault_vec;
	logic        fault_any;
	logic        eligible;
	logic [3:0]  lim_count;
	logic        lim_alarm;
	logic [11:0] wait_units;
	logic [15:0] window_units;

	// eligibility mask for a class setting
	function automatic logic [17:0] class_mask(input logic [1:0] sel);
		logic [17:0] m;
		unique case (sel)
			far_pkg::CLASS_ALL:   m = far_pkg::MASK_ALL;
			far_pkg::CLASS_OC:    m = far_pkg::MASK_OC;
			far_pkg::CLASS_OV:    m = far_pkg::MASK_OV;
			far_pkg::CLASS_OC_OV: m = far_pkg::MASK_OC | far_pkg::MASK_OV;
		endcase
		// belt and braces: hard faults stay out whatever the table says
		return m & ~far_pkg::MASK_NEVER;
	endfunction : class_mask

	// number of allowed attempts, zero for off or out-of-range settings
	function automatic logic [3:0] limit_count(input logic [6:0] lim);
		logic [3:0] n;
		n = 4'h0;
		if (lim != far_pkg::LIMIT_OFF && lim <= far_pkg::LIMIT_MAX) begin
			n = lim[3:0];
		end else if (lim >= far_pkg::LIMIT_ALM_MIN && lim <= far_pkg::LIMIT_ALM_MAX) begin
			n = 4'((lim - far_pkg::LIMIT_ALM_BASE));
		end
		return n;
	endfunction : limit_count

	// code of the highest-placed asserted fault, so one wins on a tie
	function automatic logic [4:0] fault_code(input logic [17:0] v);
		logic [4:0] c;
		c = far_pkg::CODE_NONE;
		for (int i = 0; i < 18; i++) begin
			if (v[i]) begin
				c = 5'(i + 1);
			end
		end
		return c;
	endfunction : fault_code

	// settings decode
	assign fault_vec  = i_faults;
	assign fault_any  = |fault_vec;
	// any fault outside the class mask, excluded ones included, forbids the retry
	assign eligible   = fault_any &&
	                    ((fault_vec & ~class_mask(i_cfg.retry_fault_class_select)) == '0);
	assign lim_count  = limit_count(i_cfg.retry_attempt_limit);
	assign lim_alarm  = (i_cfg.retry_attempt_limit >= far_pkg::LIMIT_ALM_MIN);

	// out-of-range wait settings are clamped rather than refused
	always_comb begin
		if (i_cfg.retry_wait_time < far_pkg::WAIT_MIN) begin
			wait_units = far_pkg::WAIT_MIN;
		end else if (i_cfg.retry_wait_time > far_pkg::WAIT_MAX) begin
			wait_units = far_pkg::WAIT_MAX;
		end else begin
			wait_units = i_cfg.retry_wait_time;
		end
	end
	// widen before the product so long wait settings do not wrap
	assign window_units = 16'(wait_units) * 16'(far_pkg::WINDOW_MULT);

	// shared timer: retry wait, then the success watch window
	far_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.TICKS_W     (16)
	) u_timer (
		.i_clk    (i_clk),
		.i_srst   (i_srst),
		.i_start  (st_r.tmr_start),
		.i_cancel (st_r.tmr_cancel),
		.i_ticks  (st_r.tmr_ticks),
		.o_busy   (),
		.o_done   (tmr_done)
	);

	// next state
	always_comb begin
		st_nxt               = st_r;
		st_nxt.fault_reset   = 1'b0;
		st_nxt.thermal_clear = 1'b0;
		st_nxt.tmr_start     = 1'b0;
		st_nxt.tmr_cancel    = 1'b0;

		unique case (st_r.state)
			// running with output on, either plain or inside a watch window
			far_pkg::ST_RUN, far_pkg::ST_WATCH: begin
				if (fault_any) begin
					st_nxt.tmr_cancel = 1'b1;
					if (eligible && lim_count != 4'h0) begin
						if (st_r.attempts < lim_count) begin
							st_nxt.state     = far_pkg::ST_WAIT;
							st_nxt.attempts  = st_r.attempts + 4'h1;
							st_nxt.alarm     = lim_alarm;
							st_nxt.tmr_start = 1'b1;
							st_nxt.tmr_ticks = 16'(wait_units);
							// later faults in the window leave the record alone
							if (st_r.record == far_pkg::CODE_NONE) begin
								st_nxt.record = fault_code(fault_vec);
							end
						end else begin
							st_nxt.state       = far_pkg::ST_STOPPED;
							st_nxt.limit_fault = 1'b1;
							st_nxt.alarm       = 1'b1;
						end
					end else begin
						// not eligible or retry off: ordinary hard stop
						st_nxt.state = far_pkg::ST_STOPPED;
						st_nxt.alarm = 1'b1;
					end
				end else if (st_r.state == far_pkg::ST_WATCH && tmr_done) begin
					// survived five waiting times with no major fault
					st_nxt.state    = far_pkg::ST_RUN;
					st_nxt.attempts = 4'h0;
					st_nxt.record   = far_pkg::CODE_NONE;
					st_nxt.alarm    = 1'b0;
				end
			end
			// output off, waiting out the programmed time
			far_pkg::ST_WAIT: begin
				if (tmr_done) begin
					st_nxt.state       = far_pkg::ST_RESTART;
					st_nxt.fault_reset = 1'b1;
				end
			end
			// one cycle for the detectors to drop their latched fault
			far_pkg::ST_RESTART: begin
				st_nxt.state     = far_pkg::ST_WATCH;
				st_nxt.alarm     = 1'b0;
				st_nxt.tmr_start = 1'b1;
				st_nxt.tmr_ticks = window_units;
			end
			// hard stop until the operator clears it
			far_pkg::ST_STOPPED: begin
				if (i_fault_clear) begin
					st_nxt.state       = far_pkg::ST_RESTART;
					st_nxt.fault_reset = 1'b1;
					st_nxt.attempts    = 4'h0;
					st_nxt.record      = far_pkg::CODE_NONE;
					st_nxt.limit_fault = 1'b0;
				end
			end
			default: begin
				st_nxt.state = far_pkg::ST_STOPPED;
				st_nxt.alarm = 1'b1;
			end
		endcase

		// counter: clear by zero write, an increment in the same cycle counts on from zero
		if (i_cnt_wr && i_cnt_wr_data == '0) begin
			st_nxt.success_cnt = '0;
		end
		if (st_r.state == far_pkg::ST_WATCH && !fault_any && tmr_done) begin
			// saturate so a long-lived drive never wraps back to zero
			if (st_nxt.success_cnt != '1) begin
				st_nxt.success_cnt = st_nxt.success_cnt + CNT_W'(1);
			end
		end
	end

	// state register; power-on reset also clears downstream thermal state
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			st_r               <= '0;
			st_r.state         <= far_pkg::ST_RUN;
			st_r.thermal_clear <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs
	assign o_output_enable              = (st_r.state == far_pkg::ST_RUN) ||
	                                      (st_r.state == far_pkg::ST_WATCH);
	assign o_fault_reset                = st_r.fault_reset;
	assign o_thermal_state_clear        = st_r.thermal_clear;
	assign o_alarm                      = st_r.alarm;
	assign o_retry_limit_exceeded_fault = st_r.limit_fault;
	assign o_retry_active               = (st_r.state == far_pkg::ST_WAIT) ||
	                                      (st_r.state == far_pkg::ST_RESTART);
	assign o_retry_attempts             = st_r.attempts;
	assign o_retry_fault_record         = st_r.record;
	assign o_retry_success_counter      = st_r.success_cnt;

endmodule : far_ctrl

`default_nettype wire

// ---- sim/far_ctrl_checker.sv ----
// checker: port-level assertions for the fault auto-retry controller
`timescale 1ns/100ps
`default_nettype none

module far_ctrl_checker #(
	parameter int unsigned TICK_CYCLES = far_pkg::TICK_CYCLES,
	parameter int unsigned CNT_W       = far_pkg::CNT_W
) (
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	// inputs
	input  wire far_pkg::far_fault_s i_faults,
	input  wire far_pkg::far_cfg_s  i_cfg,
	input  wire logic               i_cnt_wr,
	input  wire logic [CNT_W-1:0]   i_cnt_wr_data,
	// outputs
	input  wire logic               o_output_enable,
	input  wire logic               o_fault_reset,
	input  wire logic               o_thermal_state_clear,
	input  wire logic               o_alarm,
	input  wire logic               o_retry_limit_exceeded_fault,
	input  wire logic               o_retry_active,
	input  wire logic [3:0]         o_retry_attempts,
	input  wire logic [4:0]         o_retry_fault_record,
	input  wire logic [CNT_W-1:0]   o_retry_success_counter
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	logic [17:0] flt;
	logic [6:0]  lim;
	logic [6:0]  nlim;
	logic        valid;
	logic        hit;
	logic [31:0] wmax;
	logic [31:0] wait_cnt_r;

	// decoded settings; wmax carries no slack, AST_WAIT_MAX adds it for the prescaler phase
	assign flt   = i_faults;
	assign lim   = i_cfg.retry_attempt_limit;
	assign nlim  = (lim > 7'h64) ? lim - 7'h64 : lim;
	assign valid = (lim >= 7'h01 && lim <= 7'h0A) || (lim >= 7'h65 && lim <= 7'h6E);
	assign hit   = o_output_enable && (flt != 18'h00000);
	assign wmax  = 32'(i_cfg.retry_wait_time) * TICK_CYCLES;

	// cycles spent in the current retry
	always_ff @(posedge i_clk) begin
		if (i_srst || !o_retry_active)
			wait_cnt_r <= 32'h00000000;
		else
			wait_cnt_r <= wait_cnt_r + 32'h00000001;
	end

	sequence s_halt;
		!o_output_enable && o_retry_active;
	endsequence

	AST_TRIP_STOPS: assert property (hit |=> !o_output_enable)
		else $error("output stayed on after a fault");
	AST_RETRY_TAKEN: assert property (hit && valid && {3'h0, o_retry_attempts} < nlim &&
		i_cfg.retry_fault_class_select == 2'h0 && (flt & ~far_pkg::MASK_ALL) == 18'h0
		|=> s_halt) else $error("eligible fault not retried");
	AST_NEVER: assert property (hit && (flt & far_pkg::MASK_NEVER) != 18'h0
		|=> !o_retry_active) else $error("excluded fault retried");
	AST_CLASS_ONE: assert property (hit && i_cfg.retry_fault_class_select == 2'h1 &&
		(flt & far_pkg::MASK_OC) == 18'h0 |=> !o_retry_active) else $error("class one leak");
	AST_LIMIT_OFF: assert property (hit && !valid |=> !o_retry_active && o_alarm)
		else $error("retry with limit off");
	AST_ALARM_MODE: assert property (o_retry_active && $past(o_retry_active) && valid
		|-> o_alarm == (lim > 7'h64)) else $error("alarm mode wrong during retry");
	AST_WAIT_MAX: assert property (o_retry_active |-> wait_cnt_r <= wmax + TICK_CYCLES + 8)
		else $error("retry wait too long");
	AST_WAIT_MIN: assert property (o_fault_reset && wait_cnt_r > 1 |-> wait_cnt_r >= wmax)
		else $error("restart before wait time");
	AST_RESTART: assert property (o_fault_reset |=> !o_fault_reset && o_output_enable)
		else $error("restart pulse not followed by running");
	AST_THERMAL: assert property (o_thermal_state_clear |-> $past(i_srst))
		else $error("thermal state cleared outside power-on reset");
	AST_CNT_STEP: assert property (!$stable(o_retry_success_counter) |->
		o_retry_success_counter == $past(o_retry_success_counter) + 1'b1 ||
		o_retry_success_counter == '0) else $error("counter jumped");
	AST_CNT_CLEAR: assert property (i_cnt_wr && i_cnt_wr_data == '0
		|=> o_retry_success_counter <= 1) else $error("counter not cleared");
	AST_REC_HOLD: assert property ($past(o_retry_fault_record) != 5'h00 &&
		o_retry_fault_record != 5'h00 |-> $stable(o_retry_fault_record))
		else $error("fault record overwritten");
	AST_EXCEED: assert property ($rose(o_retry_limit_exceeded_fault) |->
		!o_output_enable && o_alarm) else $error("limit fault without stop");
endmodule : far_ctrl_checker

bind far_ctrl far_ctrl_checker #(.TICK_CYCLES(TICK_CYCLES), .CNT_W(CNT_W)) u_chk (
	.i_clk, .i_srst, .i_faults, .i_cfg, .i_cnt_wr, .i_cnt_wr_data, .o_output_enable,
	.o_fault_reset, .o_thermal_state_clear, .o_alarm, .o_retry_limit_exceeded_fault,
	.o_retry_active, .o_retry_attempts, .o_retry_fault_record, .o_retry_success_counter);

`default_nettype wire

// ---- sim/far_drive_model.sv ----
// model: protective fault detectors latching trips until told to drop them
`timescale 1ns/100ps
`default_nettype none

module far_drive_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	// trip request and detector reset
	input  wire logic [17:0] i_trip,
	input  wire logic        i_fault_reset,
	// latched fault levels
	output logic [17:0]      o_faults
);
	// a trip holds until reset, so a late reset shows up as a repeat fault
	always_ff @(posedge i_clk) begin
		if (i_srst || i_fault_reset)
			o_faults <= 18'h00000;
		else
			o_faults <= o_faults | i_trip;
	end
endmodule : far_drive_model

`default_nettype wire

// ---- sim/testbench.sv ----
// bench: table-driven fault scenarios for the auto-retry controller
`timescale 1ns/100ps
`default_nettype none

module testbench;
	localparam int T  = 4;
	localparam int W  = 2;
	localparam int NT = 14;
	logic                clk  = 1'b0;
	logic                srst = 1'b1;
	logic [17:0]         trip = 18'h00000;
	far_pkg::far_fault_s flt;
	far_pkg::far_cfg_s   cfg  = '{2'h0, 7'h0A, 12'h002};
	logic                wr   = 1'b0;
	logic [15:0]         wdat = 16'h0000;
	logic                fclr = 1'b0;
	logic                oe, frst, tclr, alm, exc, act;
	logic [3:0]          att;
	logic [4:0]          rec;
	logic [15:0]         cnt;
	logic [15:0]         exp_cnt = 16'h0000;
	int                  n_errors = 0;
	int                  total_checks = 0;
	int                  cyc = 0;
	// class, limit, fault bit, retried
	int tc [NT] = '{0, 0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 0, 0, 0};
	int tl [NT] = '{10, 10, 10, 10, 10, 10, 10, 10, 10, 10, 10, 0, 101, 110};
	int tbit [NT] = '{17, 11, 2, 9, 6, 15, 13, 13, 16, 12, 8, 17, 17, 4};
	int tr [NT] = '{1, 1, 1, 0, 0, 1, 0, 1, 0, 1, 0, 0, 1, 1};

	always #2.5 clk = ~clk;

	far_ctrl #(.TICK_CYCLES(T)) DUT (
		.i_clk(clk), .i_srst(srst), .i_faults(flt), .i_cfg(cfg), .i_cnt_wr(wr),
		.i_cnt_wr_data(wdat), .i_fault_clear(fclr), .o_output_enable(oe),
		.o_fault_reset(frst), .o_thermal_state_clear(tclr), .o_alarm(alm),
		.o_retry_limit_exceeded_fault(exc), .o_retry_active(act),
		.o_retry_attempts(att), .o_retry_fault_record(rec), .o_retry_success_counter(cnt));

	far_drive_model MDL (
		.i_clk(clk), .i_srst(srst), .i_trip(trip), .i_fault_reset(frst), .o_faults(flt));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// one-cycle trip; returns once the controller has reacted
	task automatic fire(input int b);
		trip[b] = 1'b1;
		@(negedge clk);
		trip = 18'h00000;
		@(negedge clk);
	endtask : fire

	// wait for the restart, then let the watch window run out clean
	task automatic recover(input logic stopped);
		int n;
		n = 0;
		fclr = stopped;
		while (!frst && n < 100) begin
			@(negedge clk);
			fclr = 1'b0;
			n++;
		end
		if (!stopped) chk(n >= W * T && n <= W * T + 6, 1);
		repeat (5 * W * T + 8) @(negedge clk);
		exp_cnt++;
		chk(cnt, exp_cnt);
		chk({oe, rec}, {1'b1, 5'h00});
	endtask : recover

	task automatic wr_cnt(input logic [15:0] d);
		wr = 1'b1;
		wdat = d;
		@(negedge clk);
		wr = 1'b0;
		@(negedge clk);
	endtask : wr_cnt

	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_of_test;
		end
	end

	initial begin
		repeat (5) @(negedge clk);
		chk(tclr, 1);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk({oe, tclr}, 2'b10);
		// every class and limit mode, and the fin overheat and phase loss excluded faults
		for (int i = 0; i < NT; i++) begin
			cfg.retry_fault_class_select = 2'(tc[i]);
			cfg.retry_attempt_limit = 7'(tl[i]);
			fire(tbit[i]);
			chk({oe, act, alm}, {1'b0, tr[i][0], !tr[i][0] || tl[i] > 100});
			if (tr[i][0]) chk({att, rec}, {4'h1, 5'(tbit[i] + 1)});
			recover(!tr[i][0]);
		end
		// second fault in the watch window with attempts used up
		cfg = '{2'h0, 7'h01, 12'h002};
		fire(17);
		repeat (W * T + 8) @(negedge clk);
		fire(13);
		chk({oe, exc, alm, act}, 4'b0110);
		chk(rec, 5'h12);
		recover(1'b1);
		// an excluded fault beside an eligible one still stops hard
		cfg = '{2'h0, 7'h0A, 12'h002};
		trip[9] = 1'b1;
		fire(17);
		chk({oe, act, alm}, 3'b001);
		recover(1'b1);
		// only a zero write clears the count
		wr_cnt(16'h0005);
		chk(cnt, exp_cnt);
		wr_cnt(16'h0000);
		chk(cnt, 16'h0000);
		end_of_test;
	end
endmodule : testbench

`default_nettype wire
